// >>> hdl/fps_top.sv
// Purpose: Flash block protection, vector redirection and security gate
// Assumes: Nonvolatile images are stable inputs from the flash array
// Notes:   APB slave with zero wait states while the clock enable is high
//
// Operation
// - Load working protection register from nonvolatile image after reset.
// - Ignore protection writes that would shrink the protected region.
// - Reject program and erase inside the protected region.
// - Background debug writes to protection register always take effect.
// - Protection image in last sector is protected while protection active.
// - Vector locations are protected whenever any flash is protected.
// - Redirection only when redirect disable bit in options image is zero.
// - Redirection only when the protection image protects some flash.
// - Interrupt vectors come from relocated table; reset vector never moves.
// - Flash and RAM are secure resources while security is engaged.
// - Register pages and debug controller are never secure resources.
// - Code running from secure memory has full access everywhere; the code still blocks it at secure resources when acc_debug is set.
// - Blocked accesses drop writes and return zero on reads.
// - Security state comes from two-bit field in working options register.
// - Copy options image into working options register in the load cycle after reset.
// - Field value one-zero disengages security.
//
// Added by the designer: the APB interface to the registers.
module fps_top
  import fps_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        apb_debug,
  // Nonvolatile images
  input  wire logic [7:0]  nv_prot_image,
  input  wire logic [7:0]  nv_opt_image,
  // Flash program and erase requests
  input  wire logic        fcmd_valid,
  input  wire logic [15:0] fcmd_addr,
  output logic             fcmd_accept,
  output logic             fcmd_reject,
  // Vector fetch
  input  wire logic        vec_req,
  input  wire logic [15:0] vec_addr,
  output logic             vec_ack,
  output logic      [15:0] vec_out_addr,
  // Memory access gate
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic [15:0] acc_addr,
  input  wire logic        acc_secure_code,
  input  wire logic        acc_debug,
  input  wire logic [7:0]  acc_rdata_in,
  output logic             acc_done,
  output logic             acc_wr_en,
  output logic             acc_blocked,
  output logic      [7:0]  acc_rdata,
  // Status
  output logic             protect_active,
  output logic             redirect_active,
  output logic             secure_engaged,
  output logic             load_done
);

  fps_state_type state_reg;
  fps_state_type state_next;

  logic [7:0]  working_protect_reg;
  logic [7:0]  working_options_reg;
  logic [7:0]  nv_prot_snap_reg;
  logic        redirect_reg;
  logic        wr_rejected_reg;

  logic        apb_write;
  logic        apb_read;
  logic        apb_mapped;
  logic        apb_ro_hit;
  logic [6:0]  protect_size_field;
  logic [6:0]  new_size_field;
  logic        new_prot_on;
  logic [16:0] cur_start;
  logic [16:0] new_start;
  logic        prot_wr_hit;
  logic        prot_wr_ok;
  logic [1:0]  security_state_field;
  logic        redirect_disable_bit;
  logic        nv_prot_on;
  logic [16:0] nv_start;
  logic        in_region;
  logic        in_last_sect;
  logic        in_vectors;
  logic        fcmd_block;
  logic [15:0] vec_mapped;
  logic        guard_secure;
  logic        guard_blocked;
  logic        running;

  // Field extraction
  assign protect_size_field   = working_protect_reg[FPS_MSB:FPS_LSB];
  assign protect_active       = !working_protect_reg[PROT_OFF_BIT];
  assign security_state_field = working_options_reg[SEC_MSB:SEC_LSB];
  assign redirect_disable_bit = working_options_reg[NORED_BIT];
  assign new_size_field       = pwdata[FPS_MSB:FPS_LSB];
  assign new_prot_on          = !pwdata[PROT_OFF_BIT];
  assign cur_start            = fps_region_start(protect_size_field);
  assign new_start            = fps_region_start(new_size_field);
  assign nv_prot_on           = !nv_prot_snap_reg[PROT_OFF_BIT];
  assign nv_start             = fps_region_start(nv_prot_snap_reg[FPS_MSB:FPS_LSB]);
  assign running              = (state_reg == FPS_ST_RUN);
  assign load_done            = running;

  // Security decode from the two-bit field
  assign secure_engaged = (security_state_field != SEC_OPEN);

  // Redirection state drives its own output
  assign redirect_active = redirect_reg;

  // Load sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= FPS_ST_RESET;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // Reset, then one load cycle, then normal operation
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FPS_ST_RESET: state_next = FPS_ST_LOAD;
      FPS_ST_LOAD:  state_next = FPS_ST_RUN;
      FPS_ST_RUN:   state_next = FPS_ST_RUN;
      default:      state_next = FPS_ST_RESET;
    endcase
  end

  // APB decode; zero wait states
  assign pready     = ce;
  assign apb_write  = psel && penable && pwrite && ce;
  assign apb_read   = psel && penable && !pwrite && ce;
  assign apb_mapped = (paddr == REG_PROT_OFS) || (paddr == REG_OPT_OFS)
                   || (paddr == REG_STAT_OFS) || (paddr == REG_NV_OFS);
  assign apb_ro_hit = apb_mapped && (paddr != REG_PROT_OFS);
  assign pslverr    = psel && penable && (!apb_mapped || (pwrite && apb_ro_hit));

  // Protection write qualification
  assign prot_wr_hit = apb_write && (paddr == REG_PROT_OFS) && running;
  always_comb begin
    prot_wr_ok = 1'b0;
    if (apb_debug) begin
      prot_wr_ok = 1'b1;
    end else if (!protect_active) begin
      prot_wr_ok = 1'b1;
    end else if (new_prot_on && (new_start <= cur_start)) begin
      prot_wr_ok = 1'b1;
    end
  end

  // Working protection register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_protect_reg <= PROT_RESET;
    end else if (ce) begin
      if (state_reg == FPS_ST_LOAD) begin
        working_protect_reg <= nv_prot_image;
      end else if (prot_wr_hit && prot_wr_ok) begin
        working_protect_reg <= pwdata[7:0];
      end
    end
  end

  // Last rejected write flag, cleared by an accepted write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_rejected_reg <= 1'b0;
    end else if (ce) begin
      if (prot_wr_hit) begin
        wr_rejected_reg <= !prot_wr_ok;
      end
    end
  end

  // Working options register and protection image snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_options_reg <= OPT_RESET;
      nv_prot_snap_reg    <= PROT_RESET;
    end else if (ce) begin
      if (state_reg == FPS_ST_LOAD) begin
        working_options_reg <= nv_opt_image;
        nv_prot_snap_reg    <= nv_prot_image;
      end
    end
  end

  // Redirection enable from the images only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      redirect_reg <= 1'b0;
    end else if (ce) begin
      redirect_reg <= running && !redirect_disable_bit && nv_prot_on;
    end
  end

  // APB read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce) begin
      if (psel && !penable && !pwrite) begin
        prdata <= 32'h00000000;
        case (paddr)
          REG_PROT_OFS: prdata[7:0] <= working_protect_reg;
          REG_OPT_OFS:  prdata[7:0] <= working_options_reg;
          REG_STAT_OFS: begin
            prdata[STAT_PROT_BIT]  <= protect_active;
            prdata[STAT_REDIR_BIT] <= redirect_reg;
            prdata[STAT_SEC_BIT]   <= secure_engaged;
            prdata[STAT_REJ_BIT]   <= wr_rejected_reg;
            prdata[STAT_LOAD_BIT]  <= running;
          end
          REG_NV_OFS: begin
            prdata[7:0]                   <= nv_prot_snap_reg;
            prdata[NV_OPT_LSB+7:NV_OPT_LSB] <= nv_opt_image;
          end
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Protected address classification for flash commands
  assign in_region    = ({1'b0, fcmd_addr} >= cur_start) && (cur_start < REGION_END);
  assign in_last_sect = (fcmd_addr >= LAST_SECT_LO);
  assign in_vectors   = (fcmd_addr >= VEC_LO);
  assign fcmd_block   = !running
                     || (protect_active && (in_region || in_last_sect || in_vectors));

  // Flash command verdict, one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcmd_accept <= 1'b0;
      fcmd_reject <= 1'b0;
    end else if (ce) begin
      fcmd_accept <= fcmd_valid && !fcmd_block;
      fcmd_reject <= fcmd_valid && fcmd_block;
    end
  end

  // Vector address mapping
  fps_vector_map u_vector_map (
    .redirect_active (redirect_reg),
    .region_start    (nv_start),
    .fetch_addr      (vec_addr),
    .mapped_addr     (vec_mapped)
  );

  // Registered vector answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_ack      <= 1'b0;
      vec_out_addr <= RESET_VEC_LO;
    end else if (ce) begin
      vec_ack <= vec_req;
      if (vec_req) begin
        vec_out_addr <= vec_mapped;
      end
    end
  end

  // Security classification of memory accesses
  fps_access_guard u_access_guard (
    .secure_engaged   (secure_engaged),
    .acc_addr         (acc_addr),
    .from_secure_code (acc_secure_code),
    .from_debug       (acc_debug),
    .is_secure_res    (guard_secure),
    .blocked          (guard_blocked)
  );

  // Gated access result, one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_done    <= 1'b0;
      acc_wr_en   <= 1'b0;
      acc_blocked <= 1'b0;
      acc_rdata   <= 8'h00;
    end else if (ce) begin
      acc_done    <= acc_valid;
      acc_wr_en   <= acc_valid && acc_write && !guard_blocked;
      acc_blocked <= acc_valid && guard_blocked;
      if (acc_valid && !acc_write) begin
        acc_rdata <= guard_blocked ? 8'h00 : acc_rdata_in;
      end
    end
  end

endmodule : fps_top

// >>> hdl/fps_pkg.sv
// Purpose: Shared constants and types for the flash protection and security block
// Assumes: 16-bit CPU address space, 8-bit protection and options images
// Notes:   APB byte offsets are word aligned; reserved bits read as zero
package fps_pkg;

  // APB register byte offsets
  localparam logic [7:0]  REG_PROT_OFS   = 8'h00;
  localparam logic [7:0]  REG_OPT_OFS    = 8'h04;
  localparam logic [7:0]  REG_STAT_OFS   = 8'h08;
  localparam logic [7:0]  REG_NV_OFS     = 8'h0C;

  // Working protection register layout
  localparam int          PROT_OFF_BIT   = 0;
  localparam int          FPS_LSB        = 1;
  localparam int          FPS_MSB        = 7;
  localparam logic [7:0]  PROT_RESET     = 8'hFF;

  // Working options register layout
  localparam int          SEC_LSB        = 0;
  localparam int          SEC_MSB        = 1;
  localparam int          NORED_BIT      = 6;
  localparam logic [1:0]  SEC_OPEN       = 2'b10;
  localparam logic [7:0]  OPT_RESET      = 8'h00;

  // Status register bit positions and options image position in the image register
  localparam int          STAT_PROT_BIT  = 0;
  localparam int          STAT_REDIR_BIT = 1;
  localparam int          STAT_SEC_BIT   = 2;
  localparam int          STAT_REJ_BIT   = 3;
  localparam int          STAT_LOAD_BIT  = 4;
  localparam int          NV_OPT_LSB     = 8;

  // Flash map
  localparam logic [15:0] NV_PROT_ADDR   = 16'hFFBD;
  localparam logic [15:0] NV_OPT_ADDR    = 16'hFFBF;
  localparam logic [15:0] VEC_LO         = 16'hFFC0;
  localparam logic [15:0] VEC_HI         = 16'hFFFD;
  localparam logic [15:0] RESET_VEC_LO   = 16'hFFFE;
  localparam logic [15:0] VEC_TABLE_SIZE = 16'h0040;
  localparam logic [15:0] LAST_SECT_LO   = 16'hFE00;
  localparam logic [8:0]  SECT_OFS_MAX   = 9'h1FF;
  localparam logic [16:0] REGION_END     = 17'h10000;

  // Resource map
  localparam logic [15:0] DP_REG_HI      = 16'h007F;
  localparam logic [15:0] RAM_LO         = 16'h0080;
  localparam logic [15:0] RAM_HI         = 16'h107F;
  localparam logic [15:0] HP_REG_LO      = 16'h1800;
  localparam logic [15:0] HP_REG_HI      = 16'h18FF;
  localparam logic [15:0] FLASH_LO       = 16'h1900;

  typedef enum logic [1:0] {
    FPS_ST_RESET = 2'b00,
    FPS_ST_LOAD  = 2'b01,
    FPS_ST_RUN   = 2'b10
  } fps_state_type;

  // First protected address for a protect size field value
  function automatic logic [16:0] fps_region_start(input logic [6:0] size_field);
    fps_region_start = {1'b0, size_field, SECT_OFS_MAX} + 17'h00001;
  endfunction : fps_region_start

endpackage : fps_pkg

// >>> hdl/fps_vector_map.sv
// Purpose: Maps a vector fetch address onto the relocated vector table
// Assumes: Region start is the first protected flash address
// Notes:   Purely combinational; the caller registers the result
module fps_vector_map
  import fps_pkg::*;
(
  // Control
  input  wire logic        redirect_active,
  input  wire logic [16:0] region_start,
  // Fetch address
  input  wire logic [15:0] fetch_addr,
  output logic      [15:0] mapped_addr
);

  logic        is_irq_vec;
  logic [15:0] table_base;

  // Interrupt vectors only; reset vector stays at its default place
  assign is_irq_vec = (fetch_addr >= VEC_LO) && (fetch_addr <= VEC_HI);

  // Table sits right below the protected region
  assign table_base = region_start[15:0] - VEC_TABLE_SIZE;

  // Same offset within the table
  always_comb begin
    mapped_addr = fetch_addr;
    if (redirect_active && is_irq_vec) begin
      mapped_addr = table_base + (fetch_addr - VEC_LO);
    end
  end

endmodule : fps_vector_map

// >>> hdl/fps_access_guard.sv
// Purpose: Classifies a memory access and decides whether security blocks it
// Assumes: Flash runs from the flash base to the top of the map
// Notes:   Combinational; register space and debug controller stay open
module fps_access_guard
  import fps_pkg::*;
(
  // Security state
  input  wire logic        secure_engaged,
  // Access context
  input  wire logic [15:0] acc_addr,
  input  wire logic        from_secure_code,
  input  wire logic        from_debug,
  // Decision
  output logic             is_secure_res,
  output logic             blocked
);

  logic in_ram;
  logic in_flash;

  // Flash and RAM are the secure resources
  assign in_ram   = (acc_addr >= RAM_LO) && (acc_addr <= RAM_HI);
  assign in_flash = (acc_addr >= FLASH_LO);

  // Registers fall outside both ranges and are never secure
  assign is_secure_res = secure_engaged && (in_ram || in_flash);

  // Secure code passes; unsecured code or debug is stopped
  assign blocked = is_secure_res && (from_debug || !from_secure_code);

endmodule : fps_access_guard

// >>> dv/fps_mem_model.sv
// Purpose: Memory array seen behind the access gate
// Assumes: Read data follows the address in the same cycle
// Notes:   Idle data changes every cycle so no stale value is seen
module fps_mem_model (
  // Clock
  input  wire logic        pclk,
  // Access
  input  wire logic        acc_valid,
  input  wire logic [15:0] acc_addr,
  output logic      [7:0]  acc_rdata_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] idle_reg = 8'h00;
  // Free-running idle pattern
  always_ff @(posedge pclk) idle_reg <= idle_reg + 8'h3B;
  // Data tied to the address while selected
  assign acc_rdata_in = acc_valid ? (acc_addr[7:0] ^ 8'h5A) : idle_reg;
endmodule : fps_mem_model

// >>> dv/fps_top_assertions.sv
// Purpose: Port checks for protection, redirection and security gate
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound into fps_top below
module fps_top_assertions
  import fps_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Requests
  input wire logic        fcmd_valid,
  input wire logic [15:0] fcmd_addr,
  input wire logic        vec_req,
  input wire logic [15:0] vec_addr,
  input wire logic        acc_valid,
  input wire logic        acc_write,
  input wire logic [15:0] acc_addr,
  input wire logic        acc_secure_code,
  input wire logic        acc_debug,
  // Answers
  input wire logic        fcmd_accept,
  input wire logic        fcmd_reject,
  input wire logic        vec_ack,
  input wire logic [15:0] vec_out_addr,
  input wire logic        acc_blocked,
  input wire logic [7:0]  acc_rdata,
  input wire logic        protect_active,
  input wire logic        redirect_active,
  input wire logic        secure_engaged,
  input wire logic        load_done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Image load steps after release
  sequence s_loading;
    !load_done ##1 !load_done ##1 load_done;
  endsequence
  property p_load;
    $rose(presetn) |-> s_loading;
  endproperty
  a_load: assert property (p_load) else $error("load steps");
  property p_fcmd;
    fcmd_valid |=> fcmd_accept != fcmd_reject;
  endproperty
  a_fcmd: assert property (p_fcmd) else $error("fcmd answer");
  property p_vec_prot;
    fcmd_valid && protect_active && fcmd_addr >= VEC_LO |=> fcmd_reject;
  endproperty
  a_vec_prot: assert property (p_vec_prot) else $error("vector erased");
  property p_nv_prot;
    fcmd_valid && protect_active && fcmd_addr >= LAST_SECT_LO |=> fcmd_reject;
  endproperty
  a_nv_prot: assert property (p_nv_prot) else $error("image erased");
  property p_rst_vec;
    vec_req && vec_addr >= RESET_VEC_LO |=> vec_ack && vec_out_addr == $past(vec_addr);
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("reset vector moved");
  property p_no_redir;
    vec_req && !redirect_active |=> vec_out_addr == $past(vec_addr);
  endproperty
  a_no_redir: assert property (p_no_redir) else $error("vector moved");
  property p_blk_rd;
    acc_valid && !acc_write && secure_engaged && !acc_secure_code
      && acc_addr inside {[RAM_LO:RAM_HI]} |=> acc_blocked && acc_rdata == 8'h00;
  endproperty
  a_blk_rd: assert property (p_blk_rd) else $error("ram read open");
  property p_regs;
    acc_valid && acc_addr inside {[HP_REG_LO:HP_REG_HI]} |=> !acc_blocked;
  endproperty
  a_regs: assert property (p_regs) else $error("regs blocked");
  property p_sec_code;
    acc_valid && acc_secure_code && !acc_debug |=> !acc_blocked;
  endproperty
  a_sec_code: assert property (p_sec_code) else $error("secure code blocked");
  property p_open;
    acc_valid && !secure_engaged |=> !acc_blocked;
  endproperty
  a_open: assert property (p_open) else $error("open part blocked");
endmodule : fps_top_assertions

bind fps_top fps_top_assertions u_chk (.pclk, .presetn, .fcmd_valid, .fcmd_addr,
  .vec_req, .vec_addr, .acc_valid, .acc_write, .acc_addr, .acc_secure_code, .acc_debug,
  .fcmd_accept, .fcmd_reject, .vec_ack, .vec_out_addr, .acc_blocked, .acc_rdata,
  .protect_active, .redirect_active, .secure_engaged, .load_done);

// >>> dv/tb.sv
// Purpose: Self-checking bench for the protection and security block
// Assumes: Clock enable held high, APB master in the bench
// Notes:   Images reloaded by repeated resets
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import fps_pkg::*;
  logic        pclk, presetn, ce, psel, penable, pwrite, apb_debug, pready, pslverr, er;
  logic [7:0]  paddr, nv_prot_image, nv_opt_image, acc_rdata_in, acc_rdata;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] fcmd_addr, vec_addr, vec_out_addr, acc_addr;
  logic        fcmd_valid, fcmd_accept, fcmd_reject, vec_req, vec_ack, acc_valid;
  logic        acc_write, acc_secure_code, acc_debug, acc_done, acc_wr_en, acc_blocked;
  logic        protect_active, redirect_active, secure_engaged, load_done;
  int          n_mismatch, samples_checked;
  logic [36:0] r;
  // Rows: kind, {write, secure code, debug}, address, expected
  logic [36:0] rows [0:14] = '{
    {2'h0, 3'h0, 16'hF9FF, 16'h0001}, {2'h0, 3'h0, 16'hFA00, 16'h0000},
    {2'h0, 3'h0, 16'h1900, 16'h0001}, {2'h0, 3'h0, 16'hFFBD, 16'h0000},
    {2'h0, 3'h0, 16'hFFC0, 16'h0000}, {2'h1, 3'h0, 16'hFFE0, 16'hF9E0},
    {2'h1, 3'h0, 16'hFFC0, 16'hF9C0}, {2'h1, 3'h0, 16'hFFFC, 16'hF9FC},
    {2'h1, 3'h0, 16'hFFFE, 16'hFFFE}, {2'h2, 3'h0, 16'h0100, 16'h0002},
    {2'h2, 3'h6, 16'h2000, 16'h0001}, {2'h2, 3'h5, 16'h0200, 16'h0002},
    {2'h2, 3'h1, 16'h1810, 16'h0000}, {2'h2, 3'h4, 16'h0010, 16'h0001},
    {2'h2, 3'h2, 16'h3000, 16'h0000}};
  // Protect writes: debug, value written, value read back
  logic [16:0] wseq [0:3] = '{17'h0FAF8, 17'h0F6F6, 17'h001F6, 17'h1FFFF};

  fps_top u_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .apb_debug, .nv_prot_image, .nv_opt_image,
    .fcmd_valid, .fcmd_addr, .fcmd_accept, .fcmd_reject, .vec_req, .vec_addr,
    .vec_ack, .vec_out_addr, .acc_valid, .acc_write, .acc_addr, .acc_secure_code,
    .acc_debug, .acc_rdata_in, .acc_done, .acc_wr_en, .acc_blocked, .acc_rdata,
    .protect_active, .redirect_active, .secure_engaged, .load_done);
  fps_mem_model u_mem (.pclk, .acc_valid, .acc_addr, .acc_rdata_in);

  // 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic dbg);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    apb_debug <= dbg;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One-cycle request: 0 flash command, 1 vector, 2 access
  task automatic op(input logic [1:0] k, input logic [15:0] a, input logic [2:0] f);
    @(posedge pclk);
    fcmd_valid <= (k == 2'h0);
    vec_req <= (k == 2'h1);
    acc_valid <= (k == 2'h2);
    fcmd_addr <= a;
    vec_addr <= a;
    acc_addr <= a;
    {acc_write, acc_secure_code, acc_debug} <= f;
    @(posedge pclk);
    fcmd_valid <= 1'b0;
    vec_req <= 1'b0;
    acc_valid <= 1'b0;
    #10;
  endtask : op

  task automatic rst(input logic [7:0] p, input logic [7:0] o);
    @(posedge pclk);
    presetn <= 1'b0;
    nv_prot_image <= p;
    nv_opt_image <= o;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    #10;
  endtask : rst

  // Hang guard
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, apb_debug, fcmd_valid, vec_req, acc_valid} = 8'h00;
    {acc_write, acc_secure_code, acc_debug, ce} = 4'h1;
    {paddr, nv_opt_image, nv_prot_image, pwdata} = 56'h00F8_0000_0000;
    {fcmd_addr, vec_addr, acc_addr} = 48'h0;
    n_mismatch = 0;
    samples_checked = 0;
    #120;
    chk("rst", {load_done, fcmd_accept, acc_done, vec_out_addr, prdata[7:0]}, 32'h0FFFE00);
    rst(8'hF8, 8'h00);
    apb(1'b0, REG_PROT_OFS, 32'h0, 1'b0);
    chk("prot", rd, 32'hF8);
    apb(1'b0, REG_OPT_OFS, 32'h0, 1'b0);
    chk("opt", rd, 32'h00);
    apb(1'b0, REG_STAT_OFS, 32'h0, 1'b0);
    chk("stat", rd, 32'h17);
    foreach (rows[i]) begin
      r = rows[i];
      op(r[36:35], r[31:16], r[34:32]);
      if (r[36:35] == 2'h0) begin
        chk("fcmd", {fcmd_accept, fcmd_reject}, {r[0], !r[0]});
      end else if (r[36:35] == 2'h1) begin
        chk("vec", {vec_ack, vec_out_addr}, {1'b1, r[15:0]});
      end else begin
        chk("acc", {acc_done, acc_blocked, acc_wr_en}, {1'b1, r[1:0]});
        if (!r[34]) chk("rdata", acc_rdata, r[1] ? 8'h00 : r[23:16] ^ 8'h5A);
      end
    end
    foreach (wseq[i]) begin
      apb(1'b1, REG_PROT_OFS, {24'h0, wseq[i][15:8]}, wseq[i][16]);
      apb(1'b0, REG_PROT_OFS, 32'h0, 1'b0);
      chk("prot_wr", {protect_active, rd}, {!wseq[i][0], 24'h0, wseq[i][7:0]});
    end
    op(2'h0, 16'hFFC0, 3'h0);
    chk("fcmd_open", fcmd_accept, 1'b1);
    apb(1'b0, 8'h10, 32'h0, 1'b0);
    chk("unmapped", {er, rd}, 33'h100000000);
    apb(1'b1, REG_OPT_OFS, 32'hFF, 1'b0);
    chk("opt_ro", er, 1'b1);
    apb(1'b0, REG_OPT_OFS, 32'h0, 1'b0);
    chk("opt_kept", rd, 32'h00);
    for (int s = 0; s < 4; s++) begin
      rst(8'hF8, 8'h40 | 8'(s));
      chk("sec", {redirect_active, secure_engaged}, {1'b0, s != 2});
    end
    rst(8'hFF, 8'h02);
    op(2'h1, 16'hFFE0, 3'h0);
    chk("no_redir", {redirect_active, vec_out_addr}, 17'h0FFE0);
    op(2'h2, 16'h0100, 3'h0);
    chk("open_rd", {acc_blocked, acc_rdata}, 9'h05A);
    op(2'h0, 16'hFFBD, 3'h0);
    chk("nv_open", fcmd_accept, 1'b1);
    end_of_test();
  end
endmodule : tb
